// File: core/pio_pkg.sv
// package holding register map, field layout and reset values of the parallel ports
package pio_pkg;
    localparam int          ADDR_W         = 4;
    localparam logic [3:0]  OFS_A_DATA     = 4'h0;
    localparam logic [3:0]  OFS_B_DATA     = 4'h1;
    localparam logic [3:0]  OFS_A_DIR      = 4'h4;
    localparam logic [3:0]  OFS_B_DIR      = 4'h5;
    localparam logic [3:0]  OFS_A_PUE      = 4'hD;
    localparam int          A_W            = 5;
    localparam int          B_W            = 8;
    localparam logic [4:0]  A_DIR_RST      = 5'h00;
    localparam logic [7:0]  B_DIR_RST      = 8'h00;
    localparam logic [4:0]  A_PUE_RST      = 5'h00;
    localparam logic [7:0]  RD_RST         = 8'h00;
    localparam int          TIM_LO_BIT     = 2;
    localparam int          SER_TX_BIT     = 0;
    localparam int          SER_RX_BIT     = 1;
    localparam int          CLK_OUT_BIT    = 7;
    localparam int          CLK_IN_BIT     = 6;
    localparam int          ADC_LO_BIT     = 2;
endpackage : pio_pkg

// File: core/pio_ports.sv
// two general-purpose parallel ports with register port and pin sharing overrides
`timescale 1ns/1ns
module pio_ports #(
    parameter int AW = pio_pkg::A_W,
    parameter int BW = pio_pkg::B_W
) (
    input  wire logic          i_ref_clk,         // system bus clock
    input  wire logic          i_rst,             // async reset, high
    input  wire logic [3:0]    i_addr,            // register offset
    input  wire logic [7:0]    i_wdata,           // write data
    input  wire logic          i_wr,              // write strobe
    input  wire logic          i_rd,              // read strobe
    output logic      [7:0]    o_rdata,           // read data, cycle after strobe
    input  wire logic [AW-1:0] i_a_pin,           // first port pin levels
    output logic      [AW-1:0] o_a_out,           // first port output value
    output logic      [AW-1:0] o_a_oe,            // first port driver enable
    output logic      [AW-1:0] o_a_pullup,        // first port pull-up on
    input  wire logic [BW-1:0] i_b_pin,           // second port pin levels
    output logic      [BW-1:0] o_b_out,           // second port output value
    output logic      [BW-1:0] o_b_oe,            // second port driver enable
    input  wire logic [AW-1:0] i_key_irq_pin_enables, // key interrupt pin enables
    output logic      [AW-1:0] o_key_wakeup_inputs,   // pins routed to key module
    input  wire logic [1:0]    i_tim_ch_active,   // timer edge/level select nonzero per channel
    input  wire logic [1:0]    i_tim_ch_oe,       // timer channel drives pin
    input  wire logic [1:0]    i_tim_ch_out,      // timer channel output level
    output logic      [1:0]    o_tim_ch_in,       // timer channel input levels
    input  wire logic          i_serial_if_enable,// serial interface enabled
    input  wire logic          i_ser_txd,         // serial transmit level
    output logic               o_ser_rxd,         // serial receive level
    input  wire logic [3:0]    i_adc_sel,         // converter pin select, one-hot
    input  wire logic          i_clk_pins_en,     // clock pins selected and enabled
    input  wire logic          i_clk_out,         // clock level to drive out
    output logic               o_clk_in           // external clock input level
);
    typedef struct packed {
        logic [AW-1:0] a_lat;
        logic [AW-1:0] a_dir;
        logic [AW-1:0] a_pue;
        logic [BW-1:0] b_lat;
        logic [BW-1:0] b_dir;
        logic [7:0]    rdata;
        logic [AW-1:0] a_out;
        logic [AW-1:0] a_oe;
        logic [AW-1:0] a_pu;
        logic [BW-1:0] b_out;
        logic [BW-1:0] b_oe;
        logic [AW-1:0] key;
        logic [1:0]    tim_in;
        logic          rxd;
        logic          ckin;
    } pio_ports_type;

    pio_ports_type st_r;
    pio_ports_type st_nxt;
    logic [AW-1:0] a_sync;
    logic [BW-1:0] b_sync;

    // pick latch for outputs, synchronised pin for inputs
    function automatic logic [7:0] pio_mux(input logic [7:0] lat, input logic [7:0] pin, input logic [7:0] dir);
        pio_mux = (lat & dir) | (pin & ~dir);
    endfunction : pio_mux

    // pin levels enter the clock domain
    pio_sync #(.W(AW)) u_sync_a (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_d       (i_a_pin),
        .o_q       (a_sync)
    );
    pio_sync #(.W(BW)) u_sync_b (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_d       (i_b_pin),
        .o_q       (b_sync)
    );

    // register writes, read mux and pin control
    always_comb begin
        st_nxt = st_r;
        // data writes reach latch regardless of direction
        if (i_wr) begin
            if (i_addr == pio_pkg::OFS_A_DATA) begin
                st_nxt.a_lat = i_wdata[AW-1:0];
            end else if (i_addr == pio_pkg::OFS_B_DATA) begin
                st_nxt.b_lat = i_wdata[BW-1:0];
            end else if (i_addr == pio_pkg::OFS_A_DIR) begin
                st_nxt.a_dir = i_wdata[AW-1:0];
            end else if (i_addr == pio_pkg::OFS_B_DIR) begin
                st_nxt.b_dir = i_wdata[BW-1:0];
            end else if (i_addr == pio_pkg::OFS_A_PUE) begin
                st_nxt.a_pue = i_wdata[AW-1:0];
            end
        end
        // read data valid only in cycle after strobe; upper bits zero on first port reads
        st_nxt.rdata = pio_pkg::RD_RST;
        if (i_rd) begin
            if (i_addr == pio_pkg::OFS_A_DATA) begin
                st_nxt.rdata = pio_mux({3'h0, st_r.a_lat}, {3'h0, a_sync}, {3'h0, st_r.a_dir});
            end else if (i_addr == pio_pkg::OFS_B_DATA) begin
                st_nxt.rdata = pio_mux(st_r.b_lat, b_sync, st_r.b_dir);
            end else if (i_addr == pio_pkg::OFS_A_DIR) begin
                st_nxt.rdata = {3'h0, st_r.a_dir};
            end else if (i_addr == pio_pkg::OFS_B_DIR) begin
                st_nxt.rdata = st_r.b_dir;
            end else if (i_addr == pio_pkg::OFS_A_PUE) begin
                st_nxt.rdata = {3'h0, st_r.a_pue};
            end
        end
        // first port drivers and pull-ups
        st_nxt.a_out = st_r.a_lat;
        st_nxt.a_oe  = st_r.a_dir;
        st_nxt.a_pu  = st_r.a_pue & ~st_r.a_dir;
        // timer channels take bits 3 and 2 when active
        for (int i = 0; i < 2; i++) begin
            if (i_tim_ch_active[i]) begin
                st_nxt.a_out[pio_pkg::TIM_LO_BIT+i] = i_tim_ch_out[i];
                st_nxt.a_oe[pio_pkg::TIM_LO_BIT+i]  = i_tim_ch_oe[i];
                st_nxt.a_pu[pio_pkg::TIM_LO_BIT+i]  = 1'b0;
            end
        end
        st_nxt.tim_in = a_sync[pio_pkg::TIM_LO_BIT+1:pio_pkg::TIM_LO_BIT];
        st_nxt.key    = a_sync & i_key_irq_pin_enables;
        // second port drivers
        st_nxt.b_out = st_r.b_lat;
        st_nxt.b_oe  = st_r.b_dir;
        if (i_serial_if_enable) begin
            st_nxt.b_out[pio_pkg::SER_TX_BIT] = i_ser_txd;
            st_nxt.b_oe[pio_pkg::SER_TX_BIT]  = 1'b1;
            st_nxt.b_oe[pio_pkg::SER_RX_BIT]  = 1'b0;
        end
        st_nxt.rxd = b_sync[pio_pkg::SER_RX_BIT];
        for (int i = 0; i < 4; i++) begin
            if (i_adc_sel[i]) begin
                st_nxt.b_oe[pio_pkg::ADC_LO_BIT+i] = 1'b0;
            end
        end
        if (i_clk_pins_en) begin
            st_nxt.b_out[pio_pkg::CLK_OUT_BIT] = i_clk_out;
            st_nxt.b_oe[pio_pkg::CLK_OUT_BIT]  = 1'b1;
            st_nxt.b_oe[pio_pkg::CLK_IN_BIT]   = 1'b0;
        end
        st_nxt.ckin = b_sync[pio_pkg::CLK_IN_BIT];
    end

    // state register; data latches are left out of the reset branch so they hold through reset
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r.a_dir  <= pio_pkg::A_DIR_RST;
            st_r.b_dir  <= pio_pkg::B_DIR_RST;
            st_r.a_pue  <= pio_pkg::A_PUE_RST;
            st_r.rdata  <= pio_pkg::RD_RST;
            st_r.a_oe   <= '0;
            st_r.a_pu   <= '0;
            st_r.b_oe   <= '0;
            st_r.a_out  <= '0;
            st_r.b_out  <= '0;
            st_r.key    <= '0;
            st_r.tim_in <= '0;
            st_r.rxd    <= 1'b0;
            st_r.ckin   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata             = st_r.rdata;
    assign o_a_out             = st_r.a_out;
    assign o_a_oe              = st_r.a_oe;
    assign o_a_pullup          = st_r.a_pu;
    assign o_b_out             = st_r.b_out;
    assign o_b_oe              = st_r.b_oe;
    assign o_key_wakeup_inputs = st_r.key;
    assign o_tim_ch_in         = st_r.tim_in;
    assign o_ser_rxd           = st_r.rxd;
    assign o_clk_in            = st_r.ckin;
endmodule : pio_ports

// File: core/pio_sync.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module pio_sync #(
    parameter int W = 8
) (
    input  wire logic         i_ref_clk, // system clock
    input  wire logic         i_rst,     // async reset, high
    input  wire logic [W-1:0] i_d,       // asynchronous levels
    output logic      [W-1:0] o_q        // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pio_sync_type;
    pio_sync_type st_r;
    pio_sync_type st_nxt;

    // first stage feeds only the second
    always_comb begin
        st_nxt.s1 = i_d;
        st_nxt.s2 = st_r.s1;
    end

    // register both stages
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_q = st_r.s2;
endmodule : pio_sync

// File: sim/pio_pins.sv
// external circuit on the pins: resolves each wire from drivers, first port pull-ups and outside levels
`timescale 1ns/1ns
module pio_pins (
    input  wire logic [4:0] i_a_out,    // first port values
    input  wire logic [4:0] i_a_oe,     // first port enables
    input  wire logic [4:0] i_a_pullup, // first port pull-ups
    input  wire logic [4:0] i_a_ext,    // outside levels, first port
    input  wire logic [7:0] i_b_out,    // second port values
    input  wire logic [7:0] i_b_oe,     // second port enables
    input  wire logic [7:0] i_b_ext,    // outside levels, second port
    output logic      [4:0] o_a_pin,    // first port wires
    output logic      [7:0] o_b_pin     // second port wires
);
    // a driven pin shows its driver, an undriven pulled-up pin reads high
    assign o_a_pin = (i_a_oe & i_a_out) | (~i_a_oe & (i_a_pullup | i_a_ext));
    assign o_b_pin = (i_b_oe & i_b_out) | (~i_b_oe & i_b_ext);
endmodule : pio_pins

// File: sim/pio_ports_asserts.sv
// checker of port pin and register read behaviour, bound to the port block
`timescale 1ns/1ns
module pio_ports_asserts (
    input wire logic       i_ref_clk,             // clock
    input wire logic       i_rst,                 // async reset, high
    input wire logic [3:0] i_addr,                // register offset
    input wire logic [7:0] i_wdata,               // write data
    input wire logic       i_wr,                  // write strobe
    input wire logic       i_rd,                  // read strobe
    input wire logic [7:0] o_rdata,               // read data
    input wire logic [4:0] o_a_oe,                // first port enables
    input wire logic [4:0] o_a_pullup,            // first port pull-ups
    input wire logic [7:0] o_b_out,               // second port values
    input wire logic [7:0] o_b_oe,                // second port enables
    input wire logic [4:0] i_key_irq_pin_enables, // key enables
    input wire logic [4:0] o_key_wakeup_inputs,   // key routed pins
    input wire logic [1:0] i_tim_ch_active,       // timer owns pin
    input wire logic [1:0] i_tim_ch_oe,           // timer drives pin
    input wire logic       i_serial_if_enable,    // serial enabled
    input wire logic       i_ser_txd,             // serial transmit
    input wire logic [3:0] i_adc_sel,             // converter select
    input wire logic       i_clk_pins_en,         // clock pins on
    input wire logic       i_clk_out              // clock level out
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // direction writes reach the drivers two edges later
    a_dir_drives: assert property (i_wr && i_addr == pio_pkg::OFS_A_DIR && i_tim_ch_active == 2'b00
        ##1 i_tim_ch_active == 2'b00 |=> o_a_oe == $past(i_wdata[4:0], 2)) else $error("first port enable wrong");
    // checked one edge after reset is seen, once the flops have taken it
    a_rst_quiet: assert property (disable iff (1'b0) i_rst |=> o_a_oe == 5'h00 && o_b_oe == 8'h00
        && o_a_pullup == 5'h00) else $error("drivers on in reset");
    a_pullup_off: assert property ((o_a_pullup & o_a_oe) == 5'h00) else $error("pull-up on output pin");
    a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside slot");
    a_rd_upper: assert property ($past(i_rd) && $past(i_addr) inside {4'h0, 4'h4, 4'hD}
        |-> o_rdata[7:5] == 3'b000) else $error("upper bits not zero");
    a_key_route: assert property ((o_key_wakeup_inputs & ~$past(i_key_irq_pin_enables)) == 5'h00)
        else $error("key input not gated");
    a_tim_own: assert property ($past(i_tim_ch_active[0]) |-> o_a_oe[2] == $past(i_tim_ch_oe[0]))
        else $error("timer pin enable wrong");
    a_ser_over: assert property ($past(i_serial_if_enable) |-> o_b_oe[1:0] == 2'b01
        && o_b_out[0] == $past(i_ser_txd)) else $error("serial pins wrong");
    a_adc_force: assert property ((o_b_oe[5:2] & $past(i_adc_sel)) == 4'h0) else $error("analog pin driven");
    a_clk_pins: assert property ($past(i_clk_pins_en) |-> o_b_oe[7:6] == 2'b10
        && o_b_out[7] == $past(i_clk_out)) else $error("clock pins wrong");
    // main scenarios reached
    c_read: cover property (i_rd ##1 o_rdata != 8'h00);
    c_tim: cover property (i_tim_ch_active[0] && i_tim_ch_oe[0]);
    c_clk: cover property (i_clk_pins_en && i_adc_sel != 4'h0);
endmodule : pio_ports_asserts

bind pio_ports pio_ports_asserts i_pio_ports_asserts (.*);

// File: sim/testbench.sv
// bench for the parallel ports: register tasks, pin scenarios and verdict
`timescale 1ns/1ns
module testbench;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ser = 1'b0, txd = 1'b0, cen = 1'b0, cout = 1'b0;
    logic       rxd, cin;
    logic [3:0] addr = 4'h0, adc = 4'h0;
    logic [7:0] wd = 8'h00, rdata, b_pin, b_out, b_oe, b_ext = 8'h00;
    logic [4:0] a_pin, a_out, a_oe, a_pu, key_out, key_en = 5'h00, a_ext = 5'h00;
    logic [1:0] tact = 2'b00, toe = 2'b00, tout = 2'b00, tin;
    int         err_total = 0, cmp_count = 0;
    always #5 clk = ~clk;
    pio_ports i_pio_ports (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_a_pin(a_pin), .o_a_out(a_out), .o_a_oe(a_oe), .o_a_pullup(a_pu), .i_b_pin(b_pin),
        .o_b_out(b_out), .o_b_oe(b_oe), .i_key_irq_pin_enables(key_en), .o_key_wakeup_inputs(key_out),
        .i_tim_ch_active(tact), .i_tim_ch_oe(toe), .i_tim_ch_out(tout), .o_tim_ch_in(tin),
        .i_serial_if_enable(ser), .i_ser_txd(txd), .o_ser_rxd(rxd), .i_adc_sel(adc), .i_clk_pins_en(cen),
        .i_clk_out(cout), .o_clk_in(cin));
    pio_pins i_pio_pins (.i_a_out(a_out), .i_a_oe(a_oe), .i_a_pullup(a_pu), .i_a_ext(a_ext), .i_b_out(b_out),
        .i_b_oe(b_oe), .i_b_ext(b_ext), .o_a_pin(a_pin), .o_b_pin(b_pin));
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
        @(posedge clk) wr <= 1'b0;
    endtask : wr_reg
    // one-cycle read strobe, data taken in the following cycle
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
        #1 check(rdata, exp);
    endtask : rd_chk
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask : settle
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    initial begin
        #100000 err_total++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_chk(pio_pkg::OFS_A_DIR, 8'h00);
        rd_chk(pio_pkg::OFS_B_DIR, 8'h00);
        rd_chk(pio_pkg::OFS_A_PUE, 8'h00);
        wr_reg(4'h2, 8'h5A);
        rd_chk(4'h2, 8'h00);
        $display("test reset values done");
        wr_reg(pio_pkg::OFS_A_DATA, 8'h15);
        wr_reg(pio_pkg::OFS_A_DIR, 8'hFF);
        rd_chk(pio_pkg::OFS_A_DIR, 8'h1F);
        settle();
        check({3'b000, a_oe}, 8'h1F);
        check({3'b000, a_out}, 8'h15);
        rd_chk(pio_pkg::OFS_A_DATA, 8'h15);
        wr_reg(pio_pkg::OFS_A_DIR, 8'h03);
        a_ext <= 5'h0A;
        settle();
        rd_chk(pio_pkg::OFS_A_DATA, 8'h09);
        wr_reg(pio_pkg::OFS_A_DATA, 8'h00);
        rd_chk(pio_pkg::OFS_A_DATA, 8'h08);
        wr_reg(pio_pkg::OFS_A_PUE, 8'hFF);
        settle();
        check({3'b000, a_pu}, 8'h1C);
        rd_chk(pio_pkg::OFS_A_DATA, 8'h1C);
        $display("test first port done");
        wr_reg(pio_pkg::OFS_B_DATA, 8'hA5);
        wr_reg(pio_pkg::OFS_B_DIR, 8'hF0);
        b_ext <= 8'h3C;
        settle();
        check(b_oe, 8'hF0);
        rd_chk(pio_pkg::OFS_B_DATA, 8'hAC);
        @(posedge clk) rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(pio_pkg::OFS_B_DIR, 8'h00);
        wr_reg(pio_pkg::OFS_B_DIR, 8'hFF);
        wr_reg(pio_pkg::OFS_A_DIR, 8'h1F);
        rd_chk(pio_pkg::OFS_B_DATA, 8'hA5);
        rd_chk(pio_pkg::OFS_A_DATA, 8'h00);
        $display("test second port and reset done");
        wr_reg(pio_pkg::OFS_A_DIR, 8'h00);
        wr_reg(pio_pkg::OFS_A_PUE, 8'h00);
        {a_ext, key_en, adc, cen, cout} <= {5'h1F, 5'h05, 4'h1, 1'b1, 1'b0};
        settle();
        check({3'b000, key_out}, 8'h05);
        check(b_oe, 8'hBB);
        check(b_out, 8'h25);
        {ser, txd, tact, toe, tout, b_ext} <= {1'b1, 1'b0, 2'b11, 2'b11, 2'b10, 8'h42};
        settle();
        check(b_oe, 8'hB9);
        check(b_out, 8'h24);
        check({3'b000, a_oe}, 8'h0C);
        check({3'b000, a_out}, 8'h08);
        check({6'h00, tin}, 8'h02);
        check({7'h00, rxd}, 8'h01);
        check({7'h00, cin}, 8'h01);
        $display("test shared pins done");
        test_done();
    end
endmodule : testbench
